/* rtl/adc_serial_result_port.v */
`timescale 1ns/1ns
`include "adc_port_defs.vh"


module adc_serial_result_port
#(
  parameter DUAL_CHANNEL      = 1,                    // Two-channel variant
  parameter EXT_DETECT_CYCLES = `EXT_DETECT_CYCLES    // Frequency pin window
)
(
  input  wire        clk,           // System clock, 100 MHz
  input  wire        reset,         // Asynchronous reset, active high
  input  wire        ce,            // Clock enable, freezes all state
  input  wire        cs_n_pin,      // Chip select pin, active low
  input  wire        sck_in,        // Serial clock pin level
  output reg         sck_out,       // Serial clock drive value
  output reg         sck_oe_n,      // Serial clock drive enable, active low
  output reg         sck_pullup_en, // Serial clock pull-up enable
  output reg         sdo_out,       // Serial data drive value
  output reg         sdo_oe_n,      // Serial data drive enable, active low
  input  wire        frequency_select_pin, // Frequency control pin
  output reg         osc_external,  // Conversion runs from frequency pin
  output reg         notch_50hz,    // Internal notch at 50Hz, else 60Hz
  output reg         conv_clk_tick, // One pulse per external clock rise
  output reg         conv_start,    // Pulse: start a conversion
  output reg         conv_channel,  // Channel of the running conversion
  input  wire        conv_done,     // Pulse: conversion finished
  input  wire [31:0] conv_raw,      // Signed raw code with conv_done
  output reg         sleep,         // Low-power sleep state
  output reg         converting     // Conversion in progress
);

  // Sequencer states
  localparam ST_BOOT  = 2'h0;
  localparam ST_CONV  = 2'h1;
  localparam ST_READY = 2'h2;
  localparam ST_SHIFT = 2'h3;

  // Divider reload and last cycle of the detect window
  localparam [31:0] ISCK_HALF_FULL = `ISCK_HALF_CYCLES;
  localparam [11:0] ISCK_HALF      = ISCK_HALF_FULL[11:0];
  localparam [31:0] DETECT_LAST    = EXT_DETECT_CYCLES - 1;

  // Synchronisers: three stages, stable once stages two and three agree
  reg  [2:0] cs_sync;
  reg  [2:0] sck_sync;
  reg  [2:0] fsel_sync;
  reg        cs_n;
  reg        sck_lvl;
  reg        fsel_lvl;
  reg        cs_n_prev;
  reg        sck_prev;
  reg        fsel_prev;

  // Sequencer, shift register and counters
  reg  [1:0]  state;
  reg  [31:0] sreg;
  reg  [4:0]  fall_count;
  reg         ext_sck_mode;
  reg         chan_next;
  reg  [2:0]  boot_count;
  reg  [11:0] isck_div;
  reg  [31:0] detect_count;
  reg         fsel_seen_edge;

  // Result word and edge strobes
  wire [31:0] packed_word;
  wire        cs_fall;
  wire        cs_rise;
  wire        ext_fall;
  wire        int_fall;
  wire        shift_fall;
  wire        fsel_rise;

  // Result word with status bits and clamping
  result_word_pack u_pack
  (
    .raw_code (conv_raw),
    .channel  (conv_channel),
    .word     (packed_word)
  );

  // Pin synchronisers
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cs_sync   <= 3'h7;
      sck_sync  <= 3'h7;
      fsel_sync <= 3'h0;
      cs_n      <= 1'b1;
      sck_lvl   <= 1'b1;
      fsel_lvl  <= 1'b0;
      cs_n_prev <= 1'b1;
      sck_prev  <= 1'b1;
      fsel_prev <= 1'b0;
    end
    else if (ce)
    begin
      cs_sync   <= {cs_sync[1:0], cs_n_pin};
      sck_sync  <= {sck_sync[1:0], sck_in};
      fsel_sync <= {fsel_sync[1:0], frequency_select_pin};
      if (cs_sync[1] == cs_sync[2])
        cs_n <= cs_sync[2];
      if (sck_sync[1] == sck_sync[2])
        sck_lvl <= sck_sync[2];
      if (fsel_sync[1] == fsel_sync[2])
        fsel_lvl <= fsel_sync[2];
      cs_n_prev <= cs_n;
      sck_prev  <= sck_lvl;
      fsel_prev <= fsel_lvl;
    end
  end

  assign cs_fall   = cs_n_prev & ~cs_n;
  assign cs_rise   = ~cs_n_prev & cs_n;
  assign fsel_rise = ~fsel_prev & fsel_lvl;

  // Host falling edges count only with select low
  assign ext_fall   = ext_sck_mode & ~cs_n & sck_prev & ~sck_lvl;
  // Internal clock falls when the divider expires on a high phase
  assign int_fall   = ~ext_sck_mode & (state == ST_SHIFT) & ~sck_oe_n
                      & sck_out & (isck_div == 12'h000);
  assign shift_fall = ext_fall | int_fall;

  // Frequency pin: toggling means external clock, else tied level
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      detect_count   <= 32'h00000000;
      fsel_seen_edge <= 1'b0;
      osc_external   <= 1'b0;
      notch_50hz     <= 1'b0;
      conv_clk_tick  <= 1'b0;
    end
    else if (ce)
    begin
      conv_clk_tick <= osc_external & fsel_rise;
      if (fsel_prev != fsel_lvl)
        fsel_seen_edge <= 1'b1;
      if (detect_count == DETECT_LAST)
      begin
        detect_count   <= 32'h00000000;
        fsel_seen_edge <= 1'b0;
        osc_external   <= fsel_seen_edge | (fsel_prev != fsel_lvl);
        notch_50hz     <= fsel_lvl;
      end
      else
        detect_count <= detect_count + 32'h00000001;
    end
  end

  // Serial clock mode and pull-up
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      boot_count    <= 3'h0;
      ext_sck_mode  <= 1'b0;
      sck_pullup_en <= 1'b0;
    end
    else if (ce)
    begin
      // Power-up sample waits until the synchroniser holds the pin level
      if (boot_count != `BOOT_LAST_COUNT)
      begin
        boot_count <= boot_count + 3'h1;
        if (boot_count == `BOOT_SAMPLE_COUNT)
          ext_sck_mode <= ~sck_lvl;
      end
      else if (cs_fall && state != ST_SHIFT)
        ext_sck_mode <= ~sck_lvl;
      sck_pullup_en <= ~ext_sck_mode;
    end
  end

  // Internal serial clock generator
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      isck_div <= 12'h000;
      sck_out  <= 1'b1;
      sck_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      if (state == ST_SHIFT && !ext_sck_mode && !cs_n && !sck_oe_n)
      begin
        if (isck_div == 12'h000)
        begin
          isck_div <= ISCK_HALF - 12'h001;
          sck_out  <= ~sck_out;
          if (int_fall && fall_count == `LAST_FALL_COUNT)
            sck_oe_n <= 1'b1;
        end
        else
          isck_div <= isck_div - 12'h001;
      end
      // Mode settles one cycle after the select fall
      else if (state == ST_READY && !ext_sck_mode && !cs_n && !cs_fall)
      begin
        isck_div <= ISCK_HALF - 12'h001;
        sck_out  <= 1'b1;
        sck_oe_n <= 1'b0;
      end
      else
      begin
        sck_out  <= 1'b1;
        sck_oe_n <= 1'b1;
      end
    end
  end

  // Conversion and readout sequencer
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state        <= ST_BOOT;
      sreg         <= 32'h00000000;
      fall_count   <= 5'h00;
      chan_next    <= 1'b0;
      conv_channel <= 1'b0;
      conv_start   <= 1'b0;
      sdo_out      <= 1'b1;
    end
    else if (ce)
    begin
      conv_start <= 1'b0;
      case (state)
        ST_BOOT:
        begin
          conv_start   <= 1'b1;
          conv_channel <= 1'b0;
          chan_next    <= (DUAL_CHANNEL != 0);
          sdo_out      <= 1'b1;
          state        <= ST_CONV;
        end
        ST_CONV:
        begin
          sdo_out <= 1'b1;
          if (conv_done)
          begin
            sreg    <= packed_word;
            sdo_out <= 1'b0;
            state   <= ST_READY;
          end
        end
        ST_READY:
        begin
          sdo_out    <= sreg[`BIT_EOC];
          fall_count <= 5'h00;
          if (!cs_n && !cs_fall && (ext_fall || !ext_sck_mode))
          begin
            state <= ST_SHIFT;
            if (ext_fall)
            begin
              sreg       <= {sreg[30:0], 1'b0};
              sdo_out    <= sreg[30];
              fall_count <= 5'h01;
            end
          end
        end
        ST_SHIFT:
        begin
          if (cs_rise)
          begin
            conv_start   <= 1'b1;
            conv_channel <= chan_next;
            chan_next    <= (DUAL_CHANNEL != 0) & ~chan_next;
            sdo_out      <= 1'b1;
            state        <= ST_CONV;
          end
          else if (shift_fall)
          begin
            if (fall_count == `LAST_FALL_COUNT)
            begin
              sdo_out      <= 1'b1;
              conv_start   <= 1'b1;
              conv_channel <= chan_next;
              chan_next    <= (DUAL_CHANNEL != 0) & ~chan_next;
              state        <= ST_CONV;
            end
            else
            begin
              sreg       <= {sreg[30:0], 1'b0};
              sdo_out    <= sreg[30];
              fall_count <= fall_count + 5'h01;
            end
          end
        end
        default:
          state <= ST_BOOT;
      endcase
    end
  end

  // Data driver, sleep and busy status
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sdo_oe_n   <= 1'b1;
      sleep      <= 1'b0;
      converting <= 1'b0;
    end
    else if (ce)
    begin
      sdo_oe_n   <= cs_n;
      sleep      <= (state == ST_READY) & cs_n;
      converting <= (state == ST_CONV) | (state == ST_BOOT);
    end
  end

endmodule // adc_serial_result_port

/* rtl/adc_port_defs.vh */
`ifndef ADC_PORT_DEFS_VH
`define ADC_PORT_DEFS_VH

// System clock
`define CLK_FREQ_HZ        100000000

// Internal serial clock rate and half period in system cycles
`define ISCK_FREQ_HZ       19200
`define ISCK_HALF_CYCLES   (`CLK_FREQ_HZ / (2 * `ISCK_FREQ_HZ))

// Power-up serial clock mode sample, once the pin synchroniser has filled
`define BOOT_SAMPLE_COUNT  3'h4
`define BOOT_LAST_COUNT    3'h5

// Window used to tell a driven frequency pin from a tied one
`define EXT_DETECT_US      1000
`define EXT_DETECT_CYCLES  (`EXT_DETECT_US * (`CLK_FREQ_HZ / 1000000))

// Notch divider for an external conversion clock
`define NOTCH_DIVIDER      2560

// Result word layout
`define WORD_BITS          32
`define BIT_EOC            31
`define BIT_CHANNEL        30
`define BIT_SIGN           29
`define BIT_RANGE          28
`define CODE_MSB           27
`define LAST_FALL_COUNT    5'h1F

// Clamp limits of the raw signed code, sub-LSB units, full scale 2^28
`define CODE_FULL_SCALE    32'sh10000000
`define CODE_CLAMP_HIGH    32'sh11FFFFFF
`define CODE_CLAMP_LOW     32'shFE000000

`endif

/* rtl/result_word_pack.v */
`timescale 1ns/1ns
`include "adc_port_defs.vh"

module result_word_pack
(
  input  wire        [31:0] raw_code,  // Signed filter output, sub-LSB units
  input  wire               channel,   // Channel of this conversion
  output reg         [31:0] word       // Packed result word
);

  reg signed [31:0] raw_s;
  reg signed [31:0] clamped;

  // Clamp, then build status bits and code field
  always @*
  begin
    raw_s = raw_code;
    if (raw_s > `CODE_CLAMP_HIGH)
      clamped = `CODE_CLAMP_HIGH;
    else if (raw_s < `CODE_CLAMP_LOW)
      clamped = `CODE_CLAMP_LOW;
    else
      clamped = raw_s;
    word = 32'h00000000;
    word[`BIT_EOC]     = 1'b0;
    word[`BIT_CHANNEL] = channel;
    word[`BIT_SIGN]    = ~clamped[31];
    word[`BIT_RANGE]   = clamped[31] |
                         (clamped >= `CODE_FULL_SCALE);
    word[`CODE_MSB:0]  = clamped[`CODE_MSB:0];
  end

endmodule // result_word_pack

/* bench/adc_port_chk.sv */
`timescale 1ns/1ns
module adc_port_chk
(
  input wire clk,           // Clock
  input wire reset,         // Reset
  input wire cs_n_pin,      // Select
  input wire sck_oe_n,      // Clock drive
  input wire sck_pullup_en, // Pull-up
  input wire sdo_out,       // Data
  input wire sdo_oe_n,      // Data drive
  input wire osc_external,  // External osc
  input wire conv_clk_tick, // Osc tick
  input wire conv_start,    // Start
  input wire conv_channel,  // Channel
  input wire conv_done,     // Done
  input wire sleep,         // Sleep
  input wire converting     // Busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Select held long enough to pass the synchroniser
  sequence s_cs_hi; cs_n_pin [*8]; endsequence
  sequence s_cs_lo; !cs_n_pin [*8]; endsequence
  // Core finish, end flag low, then busy drops a cycle later
  sequence s_done; conv_done && converting; endsequence
  sequence s_eoc; !sdo_out ##1 !converting; endsequence
  property p_hiz; s_cs_hi |-> sdo_oe_n && sck_oe_n; endproperty
  property p_drive; s_cs_lo |-> !sdo_oe_n && !sleep; endproperty
  property p_eoc; s_done |=> s_eoc; endproperty
  property p_sleep; sleep |-> !converting; endproperty
  property p_pullup; !sck_oe_n |-> sck_pullup_en; endproperty
  property p_tick; conv_clk_tick |-> osc_external || $past(osc_external); endproperty
  property p_start; conv_start |-> ##[0:2] converting; endproperty
  property p_pulse; conv_start |=> !conv_start; endproperty
  property p_chan; converting && $past(converting) |-> $stable(conv_channel); endproperty
  a_hiz: assert property (p_hiz) else $error("driven while deselected");
  a_drive: assert property (p_drive) else $error("not awake while selected");
  a_eoc: assert property (p_eoc) else $error("end flag not low after done");
  a_sleep: assert property (p_sleep) else $error("asleep while converting");
  a_pullup: assert property (p_pullup) else $error("clock driven without pull-up");
  a_tick: assert property (p_tick) else $error("tick without external osc");
  a_start: assert property (p_start) else $error("start without conversion");
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  a_chan: assert property (p_chan) else $error("channel moved mid-conversion");
endmodule // adc_port_chk

bind adc_serial_result_port adc_port_chk adc_port_chk_inst
(.clk, .reset, .cs_n_pin, .sck_oe_n, .sck_pullup_en, .sdo_out, .sdo_oe_n, .osc_external,
 .conv_clk_tick, .conv_start, .conv_channel, .conv_done, .sleep, .converting);

/* bench/host_model.sv */
`timescale 1ns/1ns
module host_model
(
  input  wire        clk,      // Bench clock
  input  wire        sdo_out,  // Data value
  input  wire        sdo_oe_n, // Data drive, active low
  input  wire        sck_pin,  // Clock line level
  output reg         cs_n,     // Select drive
  output reg         sck,      // Clock drive
  output reg         sck_en    // Clock drive on
);
  reg  sdo_q;
  wire sdo;
  // Released line shows the inverse of its last value
  always @(posedge clk)
    if (!sdo_oe_n)
      sdo_q <= sdo_out;
  assign sdo = sdo_oe_n ? ~sdo_q : sdo_out;
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    sck_en = 1'b1;
  end
  // Clock level set up before select moves
  task sel(input c, input s, input e);
    @(negedge clk) sck = s;
    sck_en = e;
    repeat (4) @(negedge clk);
    cs_n = c;
    repeat (10) @(negedge clk);
  endtask
  // Sample late in high phase, device shifts after fall
  task bits(input integer n, output reg [31:0] w);
    integer i;
    w = 32'h0;
    for (i = 0; i < n; i = i + 1)
    begin
      sck = 1'b1;
      repeat (10) @(negedge clk);
      w = {w[30:0], sdo};
      sck = 1'b0;
      repeat (10) @(negedge clk);
    end
  endtask
  // Internal mode: first bit at once, then one after each device rise
  task ibits(input integer n, output reg [31:0] w);
    integer i;
    w = {31'h0, sdo};
    for (i = 1; i < n; i = i + 1)
    begin
      @(posedge sck_pin) @(negedge clk) w = {w[30:0], sdo};
    end
  endtask
endmodule // host_model

/* bench/adc_serial_result_port_test.sv */
`timescale 1ns/1ns
module adc_serial_result_port_test;
  reg         clk, reset, ce, freq, done;
  reg  [31:0] raw, word;
  reg  [63:0] rows [0:6];
  wire        sck_out, sck_oe_n, pu, sdo_out, sdo_oe_n, osc_ext, n50, tick;
  wire        start, chan, slp, conv, cs_n, hsck, hsck_en, sck_line;
  integer     fails, checks, starts, ticks, i, k;
  assign sck_line = !sck_oe_n ? sck_out : (hsck_en ? hsck : pu);
  adc_serial_result_port #(.EXT_DETECT_CYCLES(200)) adc_serial_result_port_inst
  (.clk(clk), .reset(reset), .ce(ce), .cs_n_pin(cs_n), .sck_in(sck_line),
   .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sck_pullup_en(pu), .sdo_out(sdo_out),
   .sdo_oe_n(sdo_oe_n), .frequency_select_pin(freq), .osc_external(osc_ext),
   .notch_50hz(n50), .conv_clk_tick(tick), .conv_start(start), .conv_channel(chan),
   .conv_done(done), .conv_raw(raw), .sleep(slp), .converting(conv));
  host_model host_model_inst
  (.clk(clk), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .cs_n(cs_n), .sck(hsck),
   .sck_en(hsck_en), .sck_pin(sck_line));
  // Clock and event counters
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (start === 1'b1) starts <= starts + 1;
    if (tick === 1'b1) ticks <= ticks + 1;
  end
  task summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chkb(input [63:0] nm, input e, input g);
    checks = checks + 1;
    if (g !== e) begin fails = fails + 1; $display("BAD %0s exp %b got %b", nm, e, g); end
  endtask
  task chkw(input [63:0] nm, input [31:0] e, input [31:0] g);
    checks = checks + 1;
    if (g !== e) begin fails = fails + 1; $display("BAD %0s exp %h got %h", nm, e, g); end
  endtask
  // Core model: finish the running conversion with a raw code
  task finish(input [31:0] r);
    for (k = 0; k < 9000 && conv !== 1'b1; k = k + 1) @(negedge clk);
    repeat (5) @(negedge clk);
    done = 1'b1;
    raw = r;
    chkb("chan", (starts - 1) % 2, chan);
    @(negedge clk) done = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  initial
  begin
    #500000 fails = fails + 1;
    summarize;
  end
  initial
  begin
    {reset, ce, freq, done, raw} = {3'b110, 1'b0, 32'h0};
    {fails, checks, starts, ticks} = 0;
    rows[0] = {32'h08000000, 32'h28000000};
    rows[1] = {32'h20000000, 32'h31FFFFFF};
    rows[2] = {32'h00000000, 32'h20000000};
    rows[3] = {32'hFFFFFFFF, 32'h1FFFFFFF};
    rows[4] = {32'hF0000000, 32'h1E000000};
    rows[5] = {32'h0FFFFFFF, 32'h2FFFFFFF};
    rows[6] = {32'h10000000, 32'h30000000};
    repeat (3) @(negedge clk);
    reset = 1'b0;
    // Toggled, then tied high, then tied low frequency pin
    repeat (40) begin repeat (10) @(negedge clk); freq = ~freq; end
    chkb("osc_ext", 1'b1, osc_ext);
    chkb("ticks", 1'b1, ticks > 5);
    freq = 1'b1;
    repeat (450) @(negedge clk);
    chkb("osc_int", 1'b0, osc_ext);
    chkb("n50", 1'b1, n50);
    freq = 1'b0;
    repeat (450) @(negedge clk);
    chkb("n60", 1'b0, n50);
    chkb("pu_boot", 1'b0, pu);
    $display("frequency test done");
    host_model_inst.sel(1'b0, 1'b0, 1'b1);
    chkb("oe", 1'b0, sdo_oe_n);
    chkb("busy", 1'b1, sdo_out);
    for (i = 0; i < 7; i = i + 1)
    begin
      finish(rows[i][63:32]);
      chkb("eoc", 1'b0, sdo_out);
      host_model_inst.bits(32, word);
      chkw("word", rows[i][31:0] | ((i % 2) << 30), word);
      chkb("next", 1'b1, sdo_out);
      chkw("starts", i + 2, starts);
      $display("row %0d done", i);
    end
    // Abort mid-read, then sleep and clock pulses while deselected
    finish(32'h0);
    host_model_inst.bits(8, word);
    host_model_inst.sel(1'b1, 1'b0, 1'b1);
    chkw("abort", 9, starts);
    chkb("hiz", 1'b1, sdo_oe_n);
    finish(32'h0);
    chkb("sleep", 1'b1, slp);
    host_model_inst.bits(4, word);
    host_model_inst.sel(1'b0, 1'b0, 1'b1);
    chkb("wake", 1'b0, slp);
    ce = 1'b0;
    host_model_inst.bits(4, word);
    ce = 1'b1;
    host_model_inst.bits(32, word);
    chkw("word", 32'h20000000, word);
    $display("abort and sleep test done");
    // Internal clock mode chosen by a high clock line at select fall
    finish(32'h08000000);
    host_model_inst.sel(1'b1, 1'b1, 1'b1);
    host_model_inst.sel(1'b0, 1'b1, 1'b1);
    host_model_inst.sel(1'b0, 1'b1, 1'b0);
    chkb("pullup", 1'b1, pu);
    for (k = 0; k < 6000 && sck_oe_n !== 1'b0; k = k + 1) @(negedge clk);
    chkb("sck_drv", 1'b0, sck_oe_n);
    host_model_inst.ibits(4, word);
    chkw("iword", 32'h00000006, word);
    host_model_inst.sel(1'b1, 1'b1, 1'b1);
    chkw("istarts", 11, starts);
    chkb("sck_rel", 1'b1, sck_oe_n);
    $display("internal clock test done");
    summarize;
  end
endmodule // adc_serial_result_port_test
